// *** logic/fb_aperture_pkg.sv ***
/*
 * Shared constants for the frame buffer aperture link: address map of the
 * card's memory window, register indices, pixel depth codes and sizes.
 * Assumes a 32-bit little-endian expansion bus with byte lane n on bits 8n+7:8n.
 */
package fb_aperture_pkg;
    // ---------------------------------------------------------------------
    // Address map of the card window
    // ---------------------------------------------------------------------
    localparam int ADDR_W        = 24;
    localparam int DATA_W        = 32;
    localparam int BE_W          = 4;
    localparam int APERTURE_BIT  = 23;
    localparam int REGION_BIT    = 22;
    localparam int WORD_LSB      = 2;
    localparam int FB_WORDS      = 64;
    localparam int FB_IDX_W      = 6;
    localparam int REG_IDX_W     = 2;

    // ---------------------------------------------------------------------
    // Registers inside each half
    // ---------------------------------------------------------------------
    localparam logic [1:0] REG_DEPTH_IDX  = 2'h0;
    localparam logic [1:0] REG_PITCH_IDX  = 2'h1;
    localparam logic [1:0] REG_STATUS_IDX = 2'h2;
    localparam int DEPTH_LSB = 0;
    localparam int DEPTH_W   = 2;
    localparam int PITCH_W   = 16;
    localparam logic [15:0] PITCH_RESET = 16'h0100;

    typedef enum logic [1:0]
    {
        DEPTH_8  = 2'h0,
        DEPTH_16 = 2'h1,
        DEPTH_32 = 2'h2,
        DEPTH_1  = 2'h3
    } depth_t;

    localparam depth_t DEPTH_RESET = DEPTH_32;
    localparam int BUF_DEPTH = 2;
endpackage

// *** logic/fb_link_if.sv ***
/*
 * Request and response channels between the bus-side bridge end and the
 * frame buffer card end.  Both channels use valid and ready handshakes.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
interface fb_link_if;
    logic                                    req_valid;
    logic                                    req_ready;
    logic                                    req_write;
    logic [fb_aperture_pkg::ADDR_W-1:0]      req_addr;
    logic [fb_aperture_pkg::DATA_W-1:0]      req_data;
    logic [fb_aperture_pkg::BE_W-1:0]        req_be;
    logic                                    rsp_valid;
    logic                                    rsp_ready;
    logic [fb_aperture_pkg::DATA_W-1:0]      rsp_data;

    modport card
    (
        input  req_valid, req_write, req_addr, req_data, req_be, rsp_ready,
        output req_ready, rsp_valid, rsp_data
    );

    modport bridge
    (
        output req_valid, req_write, req_addr, req_data, req_be, rsp_ready,
        input  req_ready, rsp_valid, rsp_data
    );
endinterface

// *** logic/fb_card.sv ***
/*
 * Frame buffer card end: packed big-endian pixel store, two apertures
 * (big-endian and little-endian views) with little-endian registers, and a
 * two-entry buffer on the read data path.
 * Assumes the bridge end swaps bytes so that address n sits on lane n.
 */
`timescale 1ns/10ps
module fb_card
(
    input  wire logic                                I_SYS_CLK,
    input  wire logic                                I_RESETN,
    fb_link_if.card                                  link,
    input  wire logic [fb_aperture_pkg::FB_IDX_W-1:0] I_SCAN_IDX,
    output logic      [fb_aperture_pkg::DATA_W-1:0]   O_SCAN_DATA,
    output logic      [fb_aperture_pkg::DEPTH_W-1:0]  O_DEPTH,
    output logic      [fb_aperture_pkg::PITCH_W-1:0]  O_ROW_PITCH
);
    // ---------------------------------------------------------------------
    // Lane conversion
    // ---------------------------------------------------------------------
    // Reverses bytes inside each pixel unit so a little-endian master sees
    // its scalars in native order; units of a byte or less stay in place.
    function automatic logic [31:0] swap_unit(input logic [31:0] w, input logic [1:0] depth);
        case (depth)
            fb_aperture_pkg::DEPTH_32: swap_unit = {w[7:0], w[15:8], w[23:16], w[31:24]};
            fb_aperture_pkg::DEPTH_16: swap_unit = {w[23:16], w[31:24], w[7:0], w[15:8]};
            default:                   swap_unit = w;
        endcase
    endfunction

    function automatic logic [3:0] swap_be(input logic [3:0] b, input logic [1:0] depth);
        case (depth)
            fb_aperture_pkg::DEPTH_32: swap_be = {b[0], b[1], b[2], b[3]};
            fb_aperture_pkg::DEPTH_16: swap_be = {b[2], b[3], b[0], b[1]};
            default:                   swap_be = b;
        endcase
    endfunction

    // ---------------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------------
    logic [31:0]                                  mem_word;
    logic [31:0]                                  scan_word;
    logic [fb_aperture_pkg::DEPTH_W-1:0]          depth;
    logic [fb_aperture_pkg::PITCH_W-1:0]          pitch;
    logic [15:0]                                  write_count;
    logic                                         accept;
    logic                                         little_view;
    logic                                         reg_region;
    logic [fb_aperture_pkg::FB_IDX_W-1:0]         word_idx;
    logic [fb_aperture_pkg::REG_IDX_W-1:0]        reg_idx;
    logic [31:0]                                  store_data;
    logic [3:0]                                   store_be;
    logic [31:0]                                  read_word;

    assign accept      = link.req_valid && link.req_ready;
    assign little_view = link.req_addr[fb_aperture_pkg::APERTURE_BIT];
    assign reg_region  = link.req_addr[fb_aperture_pkg::REGION_BIT];
    assign word_idx    = link.req_addr[fb_aperture_pkg::WORD_LSB +: fb_aperture_pkg::FB_IDX_W];
    assign reg_idx     = link.req_addr[fb_aperture_pkg::WORD_LSB +: fb_aperture_pkg::REG_IDX_W];

    // The big-endian view passes lanes straight: byte address n is lane n, which
    // yields blue on the top lane for 32-bit pixels and pixel n on the low lanes.
    assign store_data = little_view ? swap_unit(link.req_data, depth) : link.req_data;
    assign store_be   = little_view ? swap_be(link.req_be, depth) : link.req_be;

    always_comb
    begin
        if (reg_region)
        begin
            // Register values keep bit 0 on lane 0 in both halves.
            case (reg_idx)
                fb_aperture_pkg::REG_DEPTH_IDX:  read_word = {30'h0, depth};
                fb_aperture_pkg::REG_PITCH_IDX:  read_word = {16'h0, pitch};
                fb_aperture_pkg::REG_STATUS_IDX: read_word = {16'h0, write_count};
                default:                         read_word = 32'h0;
            endcase
        end
        else if (little_view)
        begin
            read_word = swap_unit(mem_word, depth);
        end
        else
        begin
            read_word = mem_word;
        end
    end

    // ---------------------------------------------------------------------
    // Pixel store
    // ---------------------------------------------------------------------
    // Storage is one packed byte stream: byte k of the frame lives at word
    // k/4, lane k%4, with the MSB of each byte holding the earliest pixel at
    // sub-byte depths.
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            // Each lane owns its own bank, so every bank has a single writer.
            logic [7:0] bank [fb_aperture_pkg::FB_WORDS];

            assign mem_word[8*lane +: 8]  = bank[word_idx];
            assign scan_word[8*lane +: 8] = bank[I_SCAN_IDX];

            always_ff @(posedge I_SYS_CLK)
            begin
                if (!I_RESETN)
                begin
                    for (int i = 0; i < fb_aperture_pkg::FB_WORDS; i++)
                    begin
                        bank[i] <= 8'h00;
                    end
                end
                else if (accept && link.req_write && !reg_region && store_be[lane])
                begin
                    bank[word_idx] <= store_data[8*lane +: 8];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESETN)
        begin
            depth <= fb_aperture_pkg::DEPTH_RESET;
            pitch <= fb_aperture_pkg::PITCH_RESET;
        end
        else if (accept && link.req_write && reg_region)
        begin
            // Register writes ignore the view and are read little-endian.
            if (reg_idx == fb_aperture_pkg::REG_DEPTH_IDX && link.req_be[0])
            begin
                depth <= link.req_data[fb_aperture_pkg::DEPTH_LSB +: fb_aperture_pkg::DEPTH_W];
            end
            if (reg_idx == fb_aperture_pkg::REG_PITCH_IDX)
            begin
                if (link.req_be[0])
                begin
                    pitch[7:0] <= link.req_data[7:0];
                end
                if (link.req_be[1])
                begin
                    pitch[15:8] <= link.req_data[15:8];
                end
            end
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESETN)
        begin
            write_count <= 16'h0000;
        end
        else if (accept && link.req_write && !reg_region)
        begin
            write_count <= write_count + 16'h0001;
        end
    end

    // ---------------------------------------------------------------------
    // Read data buffer
    // ---------------------------------------------------------------------
    // Two entries let the bridge stall responses without losing a word;
    // requests are refused once both entries are in use.
    logic [31:0] buf_data [fb_aperture_pkg::BUF_DEPTH];
    logic        wr_ptr;
    logic        rd_ptr;
    logic [1:0]  count;
    logic [1:0]  next_count;
    logic        push;
    logic        pop;

    assign push = accept && !link.req_write;
    assign pop  = link.rsp_valid && link.rsp_ready;

    always_comb
    begin
        next_count = count;
        if (push && !pop)
        begin
            next_count = count + 2'h1;
        end
        else if (pop && !push)
        begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESETN)
        begin
            count          <= 2'h0;
            wr_ptr         <= 1'b0;
            rd_ptr         <= 1'b0;
            link.req_ready <= 1'b0;
            link.rsp_valid <= 1'b0;
        end
        else
        begin
            count          <= next_count;
            wr_ptr         <= wr_ptr ^ push;
            rd_ptr         <= rd_ptr ^ pop;
            link.req_ready <= next_count != 2'h2;
            link.rsp_valid <= next_count != 2'h0;
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESETN)
        begin
            buf_data[0] <= 32'h0;
            buf_data[1] <= 32'h0;
        end
        else if (push)
        begin
            buf_data[wr_ptr] <= read_word;
        end
    end

    assign link.rsp_data = buf_data[rd_ptr];

    // ---------------------------------------------------------------------
    // Scan-out side
    // ---------------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESETN)
        begin
            O_SCAN_DATA <= 32'h0;
            O_DEPTH     <= fb_aperture_pkg::DEPTH_RESET;
            O_ROW_PITCH <= fb_aperture_pkg::PITCH_RESET;
        end
        else
        begin
            O_SCAN_DATA <= scan_word;
            O_DEPTH     <= depth;
            O_ROW_PITCH <= pitch;
        end
    end
endmodule

// *** logic/fb_bridge.sv ***
/*
 * Host bridge end: takes processor word accesses and places them on the
 * little-endian link, swapping bytes in big-endian processor mode.
 * Assumes the user holds a command until the ready output accepts it.
 */
`timescale 1ns/10ps
module fb_bridge
(
    input  wire logic                                 I_SYS_CLK,
    input  wire logic                                 I_RESETN,
    fb_link_if.bridge                                 link,
    input  wire logic                                 I_BIG_ENDIAN,
    input  wire logic                                 I_CMD_VALID,
    output logic                                      O_CMD_READY,
    input  wire logic                                 I_CMD_WRITE,
    input  wire logic [fb_aperture_pkg::ADDR_W-1:0]   I_CMD_ADDR,
    input  wire logic [fb_aperture_pkg::DATA_W-1:0]   I_CMD_DATA,
    input  wire logic [fb_aperture_pkg::BE_W-1:0]     I_CMD_BE,
    output logic                                      O_RD_VALID,
    input  wire logic                                 I_RD_READY,
    output logic      [fb_aperture_pkg::DATA_W-1:0]   O_RD_DATA
);
    // ---------------------------------------------------------------------
    // Byte placement
    // ---------------------------------------------------------------------
    // Processor words number bit 0 as the MSB, so the byte at address n is
    // bits 8n..8n+7 in that numbering, i.e. the top byte for n = 0.
    function automatic logic [31:0] to_lanes(input logic [31:0] w, input logic big);
        to_lanes = big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    endfunction

    logic take;
    logic rd_take;

    assign take    = I_CMD_VALID && O_CMD_READY;
    assign rd_take = link.rsp_valid && link.rsp_ready;

    // ---------------------------------------------------------------------
    // Request channel
    // ---------------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESETN)
        begin
            link.req_valid <= 1'b0;
            link.req_write <= 1'b0;
            link.req_addr  <= '0;
            link.req_data  <= 32'h0;
            link.req_be    <= 4'h0;
            O_CMD_READY    <= 1'b0;
        end
        else if (take)
        begin
            link.req_valid <= 1'b1;
            link.req_write <= I_CMD_WRITE;
            link.req_addr  <= I_CMD_ADDR;
            link.req_data  <= to_lanes(I_CMD_DATA, I_BIG_ENDIAN);
            link.req_be    <= I_CMD_BE;
            O_CMD_READY    <= 1'b0;
        end
        else if (link.req_valid && link.req_ready)
        begin
            link.req_valid <= 1'b0;
            O_CMD_READY    <= 1'b1;
        end
        else if (!link.req_valid)
        begin
            O_CMD_READY    <= 1'b1;
        end
    end

    // ---------------------------------------------------------------------
    // Response channel
    // ---------------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESETN)
        begin
            O_RD_VALID     <= 1'b0;
            O_RD_DATA      <= 32'h0;
            link.rsp_ready <= 1'b0;
        end
        else
        begin
            if (rd_take)
            begin
                O_RD_VALID <= 1'b1;
                O_RD_DATA  <= to_lanes(link.rsp_data, I_BIG_ENDIAN);
            end
            else if (I_RD_READY)
            begin
                O_RD_VALID <= 1'b0;
            end
            link.rsp_ready <= !(rd_take || (O_RD_VALID && !I_RD_READY));
        end
    end
endmodule

// *** bench/fb_link_monitor.sv ***
/*
 * Concurrent checks on the link that joins the bridge end to the card end.
 * Assumes one clock and a synchronous active-low reset shared by both ends.
 */
`timescale 1ns/10ps
module fb_link_monitor
(
    input  wire logic                                I_SYS_CLK,
    input  wire logic                                I_RESETN,
    input  wire logic                                req_valid,
    input  wire logic                                req_ready,
    input  wire logic                                req_write,
    input  wire logic [fb_aperture_pkg::ADDR_W-1:0]  req_addr,
    input  wire logic [fb_aperture_pkg::DATA_W-1:0]  req_data,
    input  wire logic [fb_aperture_pkg::BE_W-1:0]    req_be,
    input  wire logic                                rsp_valid,
    input  wire logic                                rsp_ready,
    input  wire logic [fb_aperture_pkg::DATA_W-1:0]  rsp_data
);
    // ---------------------------------------------------------------------
    // Read words held by the card between take and hand-over
    // ---------------------------------------------------------------------
    logic       rd_take;
    logic       rsp_take;
    logic [1:0] held;

    assign rd_take  = req_valid && req_ready && !req_write;
    assign rsp_take = rsp_valid && rsp_ready;

    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESETN)
            held <= 2'h0;
        else
            held <= held + {1'b0, rd_take} - {1'b0, rsp_take};
    end

    default clocking @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RESETN);

    // ---------------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------------
    a_req_hold_steady: assert property (req_valid && !req_ready |=> req_valid && $stable(req_addr)
        && $stable(req_data) && $stable(req_write) && $stable(req_be))
        else $error("link request changed before it was taken");
    a_rsp_hold_steady: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
        else $error("read word changed before it was taken");
    a_read_answer_next: assert property (rd_take && !rsp_valid |=> rsp_valid)
        else $error("read answer did not follow take");
    a_rsp_rise_cause: assert property ($rose(rsp_valid) |-> $past(rd_take))
        else $error("read word appeared without a read take");
    a_full_buffer_refuse: assert property (held == 2'h2 |-> !req_ready)
        else $error("card ready while two words are held");
    a_one_outstanding: assert property (req_valid && req_ready |=> !req_valid)
        else $error("bridge request back to back with its take");
    a_write_no_answer: assert property (req_valid && req_ready && req_write && !rsp_valid |=> !rsp_valid)
        else $error("write produced a read word");
    a_reset_quiet_link: assert property (disable iff (1'b0) !I_RESETN |=> !req_valid && !rsp_valid && !req_ready)
        else $error("link not idle during reset");
    a_ready_on_release: assert property ($rose(I_RESETN) |-> ##[0:2] req_ready)
        else $error("card not ready after reset release");
endmodule

// *** bench/tb_frame_buffer_endian_apertures.sv ***
/*
 * Self-checking bench: bridge end and card end joined by the link interface.
 * Assumes a 10 MHz clock and synchronous active-low reset.
 */
`timescale 1ns/10ps
module tb_frame_buffer_endian_apertures;
    localparam time PERIOD = 100ns;
    logic        sys_clk;
    logic        rst_n;
    logic        big_endian;
    logic        cmd_valid;
    logic        cmd_ready;
    logic        cmd_write;
    logic [23:0] cmd_addr;
    logic [31:0] cmd_data;
    logic [3:0]  cmd_be;
    logic        rd_valid;
    logic        rd_ready;
    logic [31:0] rd_data;
    logic [5:0]  scan_idx;
    logic [31:0] scan_data;
    logic [1:0]  depth;
    logic [15:0] row_pitch;
    int          fails = 0;
    int          total_checks = 0;
    int          store_writes = 0;

    fb_link_if link();
    fb_card i_fb_card(.I_SYS_CLK(sys_clk), .I_RESETN(rst_n), .link(link.card), .I_SCAN_IDX(scan_idx),
        .O_SCAN_DATA(scan_data), .O_DEPTH(depth), .O_ROW_PITCH(row_pitch));
    fb_bridge i_fb_bridge(.I_SYS_CLK(sys_clk), .I_RESETN(rst_n), .link(link.bridge), .I_BIG_ENDIAN(big_endian),
        .I_CMD_VALID(cmd_valid), .O_CMD_READY(cmd_ready), .I_CMD_WRITE(cmd_write), .I_CMD_ADDR(cmd_addr),
        .I_CMD_DATA(cmd_data), .I_CMD_BE(cmd_be), .O_RD_VALID(rd_valid), .I_RD_READY(rd_ready),
        .O_RD_DATA(rd_data));
    fb_link_monitor i_fb_link_monitor(.I_SYS_CLK(sys_clk), .I_RESETN(rst_n), .req_valid(link.req_valid),
        .req_ready(link.req_ready), .req_write(link.req_write), .req_addr(link.req_addr),
        .req_data(link.req_data), .req_be(link.req_be), .rsp_valid(link.rsp_valid),
        .rsp_ready(link.rsp_ready), .rsp_data(link.rsp_data));

    // ---------------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------------
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_cmd_ready();
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 50)
        begin
            tick();
            n++;
        end
        check_word("command ready", 32'h1, {31'h0, cmd_ready});
    endtask

    task automatic issue(input logic wr, input logic [23:0] addr, input logic [31:0] data, input logic [3:0] be);
        tick();
        cmd_write = wr;
        cmd_addr  = addr;
        cmd_data  = data;
        cmd_be    = be;
        cmd_valid = 1'b1;
        wait_cmd_ready();
        tick();
        cmd_valid = 1'b0;
        if (wr && !addr[fb_aperture_pkg::REGION_BIT])
            store_writes++;
    endtask

    task automatic collect(input string what, input logic [31:0] exp);
        int n;
        n = 0;
        tick();
        while (rd_valid !== 1'b1 && n < 50)
        begin
            tick();
            n++;
        end
        check_word("read valid", 32'h1, {31'h0, rd_valid});
        check_word(what, exp, rd_data);
        rd_ready = 1'b1;
        tick();
        rd_ready = 1'b0;
    endtask

    task automatic read(input logic [23:0] addr, input logic [31:0] exp, input string what);
        issue(1'b0, addr, 32'h0, 4'hf);
        collect(what, exp);
    endtask

    task automatic check_scan(input logic [5:0] idx, input logic [31:0] exp);
        wait_cmd_ready();
        scan_idx = idx;
        tick();
        tick();
        check_word("scan word", exp, scan_data);
    endtask

    function automatic logic [31:0] swap32(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    // Little-endian view turns each pixel unit round; byte and bit depths pass.
    function automatic logic [31:0] le_view(input logic [1:0] d, input logic [31:0] w);
        if (d == fb_aperture_pkg::DEPTH_32)
            return swap32(w);
        if (d == fb_aperture_pkg::DEPTH_16)
            return {w[23:16], w[31:24], w[7:0], w[15:8]};
        return w;
    endfunction

    // ---------------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------------
    task automatic t_registers();
        check_word("depth output", {30'h0, fb_aperture_pkg::DEPTH_RESET}, {30'h0, depth});
        check_word("pitch output", 32'h0100, {16'h0, row_pitch});
        big_endian = 1'b0;
        read(24'h400000, 32'h2, "depth register");
        read(24'h400004, 32'h0100, "pitch register");
        issue(1'b1, 24'h400004, 32'h0000_0240, 4'hf);
        read(24'hc00004, 32'h0240, "pitch register upper half");
        check_word("pitch output", 32'h0240, {16'h0, row_pitch});
        issue(1'b1, 24'h40000c, 32'h0000_00ff, 4'hf);
        read(24'h40000c, 32'h0, "unmapped register");
        big_endian = 1'b1;
        read(24'h400004, swap32(32'h0240), "pitch register swapped");
    endtask

    task automatic t_be_pixels();
        big_endian = 1'b1;
        issue(1'b1, 24'h000004, 32'h80ff_4010, 4'hf);
        check_scan(6'h1, 32'h1040_ff80);
        issue(1'b1, 24'h000008, 32'h7c1f_83e0, 4'hf);
        check_scan(6'h2, 32'he083_1f7c);
        issue(1'b1, 24'h00000c, 32'h0102_0304, 4'hf);
        check_scan(6'h3, 32'h0403_0201);
        issue(1'b1, 24'h000014, 32'h8000_0000, 4'h1);
        issue(1'b1, 24'h000014, 32'h0000_0001, 4'h8);
        check_scan(6'h5, 32'h0100_0080);
        read(24'h000004, 32'h80ff_4010, "big-endian view word");
    endtask

    task automatic t_le_processor();
        big_endian = 1'b0;
        issue(1'b1, 24'h000010, 32'h1122_3344, 4'hf);
        check_scan(6'h4, 32'h1122_3344);
        read(24'h00000c, 32'h0403_0201, "byte pixel word");
    endtask

    task automatic t_le_view();
        big_endian = 1'b0;
        for (int d = 0; d < 4; d++)
        begin
            issue(1'b1, 24'h400000, 32'(d), 4'hf);
            read(24'h800004, le_view(2'(d), 32'h1040_ff80), "little-endian view word");
            check_word("depth output", 32'(d), {30'h0, depth});
        end
        // Writes through the little-endian view land in big-endian storage order.
        issue(1'b1, 24'h400000, 32'h1, 4'hf);
        issue(1'b1, 24'h80001c, 32'h0000_00aa, 4'h1);
        check_scan(6'h7, 32'h0000_aa00);
        issue(1'b1, 24'h400000, 32'h2, 4'hf);
        issue(1'b1, 24'h800018, 32'h1122_3344, 4'hf);
        check_scan(6'h6, 32'h4433_2211);
        read(24'h400008, 32'(store_writes), "store write count");
    endtask

    task automatic t_stall();
        big_endian = 1'b1;
        issue(1'b0, 24'h000004, 32'h0, 4'hf);
        issue(1'b0, 24'h000008, 32'h0, 4'hf);
        issue(1'b0, 24'h00000c, 32'h0, 4'hf);
        issue(1'b0, 24'h000014, 32'h0, 4'hf);
        repeat (8) tick();
        check_word("card ready while full", 32'h0, {31'h0, link.req_ready});
        check_word("request held while full", 32'h1, {31'h0, link.req_valid});
        collect("stalled word 1", 32'h80ff_4010);
        collect("stalled word 2", 32'h7c1f_83e0);
        collect("stalled word 3", 32'h0102_0304);
        collect("stalled word 4", 32'h8000_0001);
    endtask

    // ---------------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ---------------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #(PERIOD / 2) sys_clk = ~sys_clk;
    end

    initial
    begin
        rst_n      = 1'b0;
        big_endian = 1'b0;
        cmd_valid  = 1'b0;
        cmd_write  = 1'b0;
        cmd_addr   = '0;
        cmd_data   = '0;
        cmd_be     = '0;
        rd_ready   = 1'b0;
        scan_idx   = '0;
        repeat (10) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        tick();
        check_scan(6'h3f, 32'h0);
        t_registers();
        t_be_pixels();
        t_le_processor();
        t_le_view();
        t_stall();
        complete_run();
    end

    initial
    begin
        #(PERIOD * 20000);
        fails++;
        $display("[FAIL] run length expected finish seen timeout");
        complete_run();
    end
endmodule
